// *** design/dac_map.svh ***
// Purpose: named widths, depths, reset levels and timing figures
// Assumes: included by the package and by every design module
// Notes:   definitions only
`ifndef DAC_MAP_SVH
`define DAC_MAP_SVH

`define DAC_WORD_W        12
`define DAC_BIN_W         8
`define DAC_SEG_W         4
`define DAC_SEG_N         15
`define DAC_SEG_LSB       8
`define DAC_FIFO_DEPTH    16
`define DAC_CLK_PERIOD_NS 100
`define DAC_MIN_SAMPLE_NS 10
`define DAC_LVL_LOW       1'b0
`define DAC_LVL_HIGH      1'b1

`endif

// *** design/dac_pkg.sv ***
// Purpose: shared types of the converter front end
// Assumes: dac_map.svh holds all widths
// Notes:   cell controls travel as one packed struct
`include "dac_map.svh"

package dac_pkg;

  // one sample word as presented by the source
  typedef logic [`DAC_WORD_W-1:0] sample_word_t;

  // upper four bits of a sample word
  typedef logic [`DAC_SEG_W-1:0] seg_code_t;

  // one set of current-cell controls
  typedef struct packed {
    logic [`DAC_SEG_N-1:0] seg_en;         // thermometer segment enables
    logic [`DAC_BIN_W-1:0] binary_ladder;  // binary-weighted cell controls
  } cell_ctrl_t;

endpackage

// *** design/sample_fifo.sv ***
// Purpose: sample buffer with valid and ready on both sides
// Assumes: DEPTH is a power of two, one clock
// Notes:   pointers carry one extra wrap bit for honest full and empty
`timescale 1ns/100ps
`include "dac_map.svh"

module sample_fifo #(
  parameter int W     = `DAC_WORD_W,
  parameter int DEPTH = `DAC_FIFO_DEPTH
) (
  input  wire logic                     i_clk,       // core clock
  input  wire logic                     i_rst_n,     // synchronised reset, active low
  input  wire logic                     i_in_valid,  // source offers a word
  output logic                          o_in_ready,  // room for a word
  input  wire logic [W-1:0]             i_in_data,   // word offered
  output logic                          o_out_valid, // a word is waiting
  input  wire logic                     i_out_ready, // drain takes the word
  output logic [W-1:0]                  o_out_data,  // oldest word
  output logic [$clog2(DEPTH):0]        o_level      // words held
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  wr_d;
  logic [AW:0]  rd_q;
  logic [AW:0]  rd_d;
  logic         push;
  logic         pop;
  logic         full;

  // status from the pointers
  assign full        = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign o_in_ready  = !full;
  assign o_out_valid = (wr_q != rd_q);
  assign o_out_data  = mem[rd_q[AW-1:0]];
  assign o_level     = wr_q - rd_q;

  // next pointer values
  always_comb begin
    push = i_in_valid && o_in_ready;
    pop  = o_out_valid && i_out_ready;
    wr_d = wr_q + {{AW{1'b0}}, push};
    rd_d = rd_q + {{AW{1'b0}}, pop};
  end

  // pointer registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // storage, no reset needed
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= i_in_data;
    end
  end

endmodule

// *** design/dac_input_register_decoder.sv ***
// Purpose: input register and segment decoder feeding the current cells
// Assumes: source logic runs on i_core_clk; no software registers
// Notes:   code and cell controls hold no reset; o_code_loaded marks validity
`timescale 1ns/100ps
`include "dac_map.svh"

module dac_input_register_decoder
  import dac_pkg::*;
#(
  parameter int FIFO_DEPTH = `DAC_FIFO_DEPTH
) (
  input  wire logic         i_core_clk,     // core clock, 10 MHz
  input  wire logic         i_rst_n,        // async reset, active low
  input  wire sample_word_t i_sample_word,  // word from the source
  input  wire logic         i_sample_valid, // word offered
  output logic              o_sample_ready, // buffer has room
  input  wire logic         i_drain_hold,   // stall the holding register
  output sample_word_t      o_sample_word,  // registered code
  output cell_ctrl_t        o_true_cells,   // cells steered to true output
  output cell_ctrl_t        o_comp_cells,   // cells steered to complement
  output logic              o_code_loaded   // a code has been captured
);
  localparam int CLK_NS     = `DAC_CLK_PERIOD_NS;
  localparam int SAMPLE_NS  = `DAC_MIN_SAMPLE_NS;
  localparam int SAMPLE_CYC = ((SAMPLE_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 :
                              ((SAMPLE_NS + CLK_NS - 1) / CLK_NS);
  localparam int LW         = $clog2(FIFO_DEPTH) + 1;

  // thermometer decode, also used by the checks
  function automatic logic [`DAC_SEG_N-1:0] thermo(input seg_code_t c);
    logic [`DAC_SEG_N-1:0] t;
    t = '0;
    for (int i = 0; i < `DAC_SEG_N; i++) begin
      t[i] = (c > seg_code_t'(i));
    end
    return t;
  endfunction

  logic         rst_meta_q;
  logic         rst_n_q;
  logic         fifo_valid;
  sample_word_t fifo_data;
  logic [LW-1:0] fifo_level;
  logic         pop;
  sample_word_t code_q;
  sample_word_t code_d;
  cell_ctrl_t   true_q;
  cell_ctrl_t   true_d;
  cell_ctrl_t   comp_q;
  cell_ctrl_t   comp_d;
  logic         loaded_q;
  logic         loaded_d;

  // reset release through two flip-flops
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= `DAC_LVL_LOW;
      rst_n_q    <= `DAC_LVL_LOW;
    end else begin
      rst_meta_q <= `DAC_LVL_HIGH;
      rst_n_q    <= rst_meta_q;
    end
  end

  // sample buffer between source and holding register
  sample_fifo #(
    .W     (`DAC_WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_core_clk),
    .i_rst_n     (rst_n_q),
    .i_in_valid  (i_sample_valid),
    .o_in_ready  (o_sample_ready),
    .i_in_data   (i_sample_word),
    .o_out_valid (fifo_valid),
    .i_out_ready (!i_drain_hold),
    .o_out_data  (fifo_data),
    .o_level     (fifo_level)
  );

  // a word moves into the holding register
  assign pop = fifo_valid && !i_drain_hold;

  // next code and cell controls, decoded ahead of the register
  always_comb begin
    code_d = code_q;
    true_d = true_q;
    comp_d = comp_q;
    if (pop) begin
      code_d               = fifo_data;
      true_d.binary_ladder = fifo_data[`DAC_BIN_W-1:0];
      true_d.seg_en        = thermo(fifo_data[`DAC_WORD_W-1:`DAC_SEG_LSB]);
      comp_d               = ~true_d;
    end
  end

  // holding register right at the cell controls, no reset
  always_ff @(posedge i_core_clk) begin
    code_q <= code_d;
    true_q <= true_d;
    comp_q <= comp_d;
  end

  // validity flag
  always_comb begin
    loaded_d = loaded_q || pop;
  end

  always_ff @(posedge i_core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      loaded_q <= `DAC_LVL_LOW;
    end else begin
      loaded_q <= loaded_d;
    end
  end

  // outputs straight from flip-flops
  assign o_sample_word = code_q;
  assign o_true_cells  = true_q;
  assign o_comp_cells  = comp_q;
  assign o_code_loaded = loaded_q;

  // checks

  // a word taken from the buffer
  sequence s_take;
    pop;
  endsequence

  // the same word seen at the register next edge
  sequence s_capture(sample_word_t w);
    ##1 (o_sample_word == $past(w));
  endsequence

  a_capture_whole_word: assert property (
    @(posedge i_core_clk) disable iff (!rst_n_q)
    s_take |-> s_capture(fifo_data))
    else $error("taken word not in holding register");

  a_cells_with_code: assert property (
    @(posedge i_core_clk) disable iff (!rst_n_q)
    s_take |=> (o_true_cells.binary_ladder == $past(fifo_data[`DAC_BIN_W-1:0]))
               && (o_true_cells.seg_en == thermo(o_sample_word[`DAC_WORD_W-1:`DAC_SEG_LSB])))
    else $error("cell controls not updated with code");

  a_binary_direct: assert property (
    @(posedge i_core_clk) disable iff (!rst_n_q || !o_code_loaded)
    o_true_cells.binary_ladder == o_sample_word[`DAC_BIN_W-1:0])
    else $error("binary cells differ from low code bits");

  a_segment_count: assert property (
    @(posedge i_core_clk) disable iff (!rst_n_q || !o_code_loaded)
    $countones(o_true_cells.seg_en) ==
      int'(o_sample_word[`DAC_WORD_W-1:`DAC_SEG_LSB]))
    else $error("segment count differs from high code bits");

  a_code_extremes: assert property (
    @(posedge i_core_clk) disable iff (!rst_n_q || !o_code_loaded)
    ((&o_sample_word) |-> (o_comp_cells == '0)) and
    ((o_sample_word == '0) |-> (o_true_cells == '0)) and
    ((o_sample_word == sample_word_t'(1) << (`DAC_WORD_W-1)) |->
      ($countones(o_true_cells.seg_en) == `DAC_SEG_N / 2 + 1) &&
      (o_true_cells.binary_ladder == '0)))
    else $error("straight binary extremes wrong");

  a_steer_exclusive: assert property (
    @(posedge i_core_clk) disable iff (!rst_n_q || !o_code_loaded)
    ((o_true_cells & o_comp_cells) == '0) && ((o_true_cells | o_comp_cells) == '1))
    else $error("cell steered to both or neither output");

  a_segment_carry: assert property (
    @(posedge i_core_clk) disable iff (!rst_n_q || !o_code_loaded)
    (o_true_cells.seg_en != $past(o_true_cells.seg_en)) |->
      (o_sample_word[`DAC_WORD_W-1:`DAC_SEG_LSB] !=
       $past(o_sample_word[`DAC_WORD_W-1:`DAC_SEG_LSB])))
    else $error("segments changed inside a 256 block");

  a_full_rate_accept: assert property (
    @(posedge i_core_clk) disable iff (!rst_n_q)
    (int'(fifo_level) < FIFO_DEPTH) |-> o_sample_ready)
    else $error("ready low while buffer has room");

  a_stream_through: assert property (
    @(posedge i_core_clk) disable iff (!rst_n_q)
    (i_sample_valid && o_sample_ready && (fifo_level == '0)) |=>
      ##[0:SAMPLE_CYC] fifo_valid)
    else $error("taken word not at buffer head next cycle");

  a_hold_last: assert property (
    @(posedge i_core_clk) disable iff (!rst_n_q || !o_code_loaded)
    !pop |=> $stable(o_sample_word) && $stable(o_true_cells) && $stable(o_comp_cells))
    else $error("register changed without a capture");

  // full buffer must refuse the source
  a_buffer_refuse: assert property (
    @(posedge i_core_clk) disable iff (!rst_n_q)
    (int'(fifo_level) == FIFO_DEPTH) |-> !o_sample_ready)
    else $error("ready high while buffer full");

  // first capture marks the code valid
  a_first_capture: assert property (
    @(posedge i_core_clk) disable iff (!rst_n_q)
    s_take |=> o_code_loaded)
    else $error("capture did not mark code valid");

  // validity stays until reset
  a_loaded_sticky: assert property (
    @(posedge i_core_clk) disable iff (!rst_n_q)
    o_code_loaded |=> o_code_loaded)
    else $error("validity flag dropped without reset");

  // a capture inside the same 256-code block
  sequence s_same_block;
    pop && (fifo_data[`DAC_WORD_W-1:`DAC_SEG_LSB] ==
            o_sample_word[`DAC_WORD_W-1:`DAC_SEG_LSB]);
  endsequence

  a_carry_hold: assert property (
    @(posedge i_core_clk) disable iff (!rst_n_q || !o_code_loaded)
    s_same_block |=> $stable(o_true_cells.seg_en))
    else $error("segments moved without a block carry");

endmodule

// *** sim/sample_source.sv ***
// Purpose: parallel sample source on the far side of the input register
// Assumes: one word per call, sent on the falling edge
// Notes:   a released bus shows the inverse of its last word
`timescale 1ns/100ps

module sample_source
  import dac_pkg::*;
(
  input  wire logic   i_clk,   // core clock
  input  wire logic   i_ready, // buffer has room
  output logic        o_valid, // word offered
  output sample_word_t o_word  // word on the bus
);
  initial begin
    o_valid = 1'b0;
    o_word  = 12'h000;
  end

  // offer a word, hold it until a rising edge sees ready, one word a cycle
  task automatic send(input sample_word_t w, output bit ok);
    int n;
    n = 0;
    @(negedge i_clk);
    o_valid = 1'b1;
    o_word  = w;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_ready !== 1'b1 && n < 200);
    ok = (i_ready === 1'b1);
  endtask

  // release the bus, leave no stale word behind
  task automatic idle();
    @(negedge i_clk);
    o_valid = 1'b0;
    o_word  = ~o_word;
  endtask
endmodule

// *** sim/tb_top.sv ***
// Purpose: self-checking bench for the input register and segment decoder
// Assumes: source model drives the stream, bench drives the stall input
// Notes:   expected codes queue in send order, monitor pops one per capture
`timescale 1ns/100ps

module tb_top;
  import dac_pkg::*;
  int           n_errors;
  int           comparisons;
  int           cnt;
  int           seed;
  logic         clk;
  logic         rst_n;
  logic         hold;
  logic         valid;
  logic         ready;
  logic         loaded;
  sample_word_t word;
  sample_word_t out_word;
  sample_word_t kept;
  cell_ctrl_t   tcells;
  cell_ctrl_t   ccells;
  sample_word_t exp_q[$];
  `define CHK(nm, e, g) begin \
    comparisons++; \
    if ((e) !== (g)) begin \
      n_errors++; \
      $display("ERROR %s exp %h got %h", nm, e, g); \
    end \
  end

  dac_input_register_decoder #(.FIFO_DEPTH(16)) dac_input_register_decoder_i (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_sample_word(word), .i_sample_valid(valid),
    .o_sample_ready(ready), .i_drain_hold(hold), .o_sample_word(out_word),
    .o_true_cells(tcells), .o_comp_cells(ccells), .o_code_loaded(loaded));
  sample_source sample_source_i (.i_clk(clk), .i_ready(ready), .o_valid(valid), .o_word(word));

  // 10 mhz core clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // expected cell controls, lowest segments first
  function automatic cell_ctrl_t decode(sample_word_t w);
    cell_ctrl_t  c;
    logic [15:0] t;
    t = (16'h0001 << w[11:8]) - 16'h0001;
    c.seg_en        = t[14:0];
    c.binary_ladder = w[7:0];
    return c;
  endfunction

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // send through the source and note the expected code
  task automatic push(input sample_word_t w);
    bit ok;
    sample_source_i.send(w, ok);
    if (!ok) begin
      n_errors++;
      wrap_up();
    end
    exp_q.push_back(w);
  endtask

  // buffer depth model, four compares per capture edge
  always @(posedge clk) begin
    bit           cap;
    sample_word_t e;
    cap = (cnt > 0) && (hold === 1'b0) && (rst_n === 1'b1);
    cnt = cnt + ((valid === 1'b1 && ready === 1'b1) ? 1 : 0) - (cap ? 1 : 0);
    if (cap) begin
      #1;
      if (exp_q.size() == 0) begin
        `CHK("spare capture", 1'b0, 1'b1)
      end else begin
        e = exp_q.pop_front();
        `CHK("code", e, out_word)
        `CHK("true cells", decode(e), tcells)
        `CHK("comp cells", ~decode(e), ccells)
        `CHK("loaded", 1'b1, loaded)
      end
    end
  end

  // bound on the whole run
  initial begin
    #(100 * 20000);
    n_errors++;
    wrap_up();
  end

  // main sequence
  initial begin
    sample_word_t tbl[7];
    int           i;
    tbl = '{12'hfff, 12'h800, 12'h000, 12'h0ff, 12'h100, 12'h1ff, 12'h200};
    n_errors = 0;
    comparisons = 0;
    cnt = 0;
    seed = 32'h553b50e9;
    rst_n = 1'b0;
    hold = 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK("loaded at reset", 1'b0, loaded)
    `CHK("ready at reset", 1'b1, ready)
    // table codes and the 255 to 256 carry, back to back
    foreach (tbl[k]) push(tbl[k]);
    // every segment count with random low bits
    for (i = 0; i < 16; i++) push({i[3:0], 8'($random(seed))});
    // random words, mostly back to back, some slow gaps
    for (i = 0; i < 40; i++) begin
      push(12'($random(seed)));
      if (($random(seed) & 3) == 0) begin
        sample_source_i.idle();
        repeat (2) @(negedge clk);
      end
    end
    sample_source_i.idle();
    repeat (4) @(negedge clk);
    // stall the register, fill the buffer until it refuses
    hold = 1'b1;
    kept = out_word;
    for (i = 0; i < 16; i++) push(12'($random(seed)));
    sample_source_i.idle();
    `CHK("ready when full", 1'b0, ready)
    repeat (5) @(negedge clk);
    `CHK("held code", kept, out_word)
    hold = 1'b0;
    push(12'habc);
    sample_source_i.idle();
    repeat (24) @(posedge clk);
    `CHK("notes left", 0, exp_q.size())
    // mid-run reset clears the flag, the unreset code holds
    @(negedge clk) rst_n = 1'b0;
    @(negedge clk);
    `CHK("loaded in reset", 1'b0, loaded)
    `CHK("code kept in reset", 12'habc, out_word)
    wrap_up();
  end
endmodule
